// ==== hdl/msd_max_select_datapath.v ====
// Maximum-selection datapath: signed half, wide and conditional unsigned max.
//
// Function
// - Half max compares selected half and operand signed, keeps larger.
// - Half max sets negative flag when half was below operand.
// - Half max sets zero flag when half equals operand.
// - Half max sets overflow when half below operand, never clears it.
// - Conditional unsigned max decoded from its pattern; not repeatable.
// - Negative set, zero clear: product register loads operand.
// - Negative clear, zero set, product below operand: load and set V.
// - Negative and zero both clear: product register unchanged.
// - Conditional compare is unsigned over the full 32 bits.
// - Conditional max sets overflow only in compare-and-load case.
// - Under a repeat prefix the conditional max clears count, runs once.
// - Wide max on the sum register decoded from its opcode pattern.
// - Wide max loads operand when sum register is below it.
// - Wide max sets zero flag when sum register equals operand.
// - Wide max negative flag from extended-precision difference sign.
// - Wide max clears carry on borrow, sets it otherwise.
// - Wide max sets overflow when sum below operand, never clears it.
// - Repeated wide max runs count plus one; overflow latches.
`timescale 1ns/1ps
`default_nettype none
`include "msd_map.vh"

// ==========================================================================
// Issue protocol
// ==========================================================================
// An instruction is taken on a rising edge that sees issue_valid_i and
// issue_ready_o high and repeat_prefix_i low. A prefix wins over an
// instruction in the same cycle and only arms the repeat counter.
// A single pass shows its results and the done_o pulse one cycle after
// the take. A repeated instruction keeps issue_ready_o low while its
// replay passes run, and done_o follows the last of them.
// Direct loads may meet an executing instruction in one cycle; the
// instruction then wins on every field that it writes.
// An unknown opcode changes no architectural state, pulses illegal_o and
// drops a pending repeat; the count register keeps its value.
module msd_max_select_datapath (
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Instruction issue from the decode and fetch pipeline.
    input  wire        issue_valid_i,
    input  wire [31:0] opcode_i,
    input  wire [31:0] operand_i,
    output wire        issue_ready_o,
    // Repeat prefix: load the count for the next instruction.
    input  wire        repeat_prefix_i,
    input  wire [15:0] repeat_count_i,
    // Register load ports from the rest of the core.
    input  wire        sum_load_i,
    input  wire [31:0] sum_load_data_i,
    input  wire        prod_load_i,
    input  wire [31:0] prod_load_data_i,
    input  wire        flag_load_i,
    input  wire [3:0]  flag_load_data_i,
    // Architectural state.
    output wire [31:0] main_sum_register_o,
    output wire [31:0] product_reg_o,
    output wire [15:0] repeat_count_reg_o,
    output wire        flag_n_o,
    output wire        flag_z_o,
    output wire        flag_c_o,
    output wire        flag_v_o,
    output wire        busy_o,
    output wire        done_o,
    output wire        illegal_o
);

    // ======================================================================
    // State and decode
    // ======================================================================
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_REPT = 2'b10;

    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg [31:0] sum_q;
    reg [31:0] sum_d;
    reg [31:0] prod_q;
    reg [31:0] prod_d;
    reg [15:0] cnt_q;
    reg [15:0] cnt_d;
    reg        n_q;
    reg        n_d;
    reg        z_q;
    reg        z_d;
    reg        c_q;
    reg        c_d;
    reg        v_q;
    reg        v_d;
    reg        armed_q;
    reg        armed_d;
    reg        done_q;
    reg        done_d;
    reg        ill_q;
    reg        ill_d;
    reg        hsel_q;
    reg        hsel_d;
    reg        wide_q;
    reg        wide_d;
    reg [31:0] opnd_q;
    reg [31:0] opnd_d;

    // Bits 7:0 only locate the operand, which the fetch side has already
    // resolved, so decode looks at the upper 24 bits alone. The half max
    // pattern masks out its select bit; the other two match exactly.
    wire [23:0] opc_top = opcode_i[`MSD_OPC_TOP:`MSD_OPC_LOW];
    wire dec_half = (opc_top & `MSD_OPC_HALF_MASK) == `MSD_OPC_HALF_MAX;
    wire dec_cond = opc_top == `MSD_OPC_COND_MAX;
    wire dec_wide = opc_top == `MSD_OPC_WIDE_MAX;

    // ======================================================================
    // Compare units
    // ======================================================================
    // The operands in flight come from the latched copy while repeating.
    wire        use_wide = (state_q == ST_REPT) ? wide_q : dec_wide;
    wire        use_hsel = (state_q == ST_REPT) ? hsel_q
                           : opcode_i[`MSD_HALF_SEL_BIT];
    wire [31:0] use_opnd = (state_q == ST_REPT) ? opnd_q : operand_i;

    // Half max: select the word and compare it signed. A plain compare
    // would rank a negative half above every positive operand.
    wire [15:0] half_val = use_hsel ? sum_q[31:16] : sum_q[15:0];
    wire [15:0] half_op  = use_opnd[15:0];
    wire        half_lt;
    wire        half_eq;

    msd_cmp #(
        .W(16)
    ) msd_cmp_half_inst (
        .a_i   (half_val),
        .b_i   (half_op),
        .lt_o  (half_lt),
        .eq_o  (half_eq),
        .brw_o ()
    );

    // Wide max: the widened signed difference keeps the true sign even
    // where a 32-bit one would overflow; the unsigned one gives the borrow.
    wire        wide_lt;
    wire        wide_eq;
    wire        wide_brw;

    msd_cmp #(
        .W(32)
    ) msd_cmp_wide_inst (
        .a_i   (sum_q),
        .b_i   (use_opnd),
        .lt_o  (wide_lt),
        .eq_o  (wide_eq),
        .brw_o (wide_brw)
    );

    // Conditional max: full-width unsigned compare on the live operand,
    // since this instruction never replays.
    wire        prod_lt = prod_q < operand_i;

    // ======================================================================
    // Next-state logic
    // ======================================================================
    reg exec;

    always @* begin
        // Defaults hold every register; pulses fall back to zero.
        state_d = state_q;
        sum_d   = sum_q;
        prod_d  = prod_q;
        cnt_d   = cnt_q;
        n_d     = n_q;
        z_d     = z_q;
        c_d     = c_q;
        v_d     = v_q;
        armed_d = armed_q;
        done_d  = 1'b0;
        ill_d   = 1'b0;
        hsel_d  = hsel_q;
        wide_d  = wide_q;
        opnd_d  = opnd_q;
        exec    = 1'b0;

        // Direct loads go first so that an executing instruction, handled
        // further down, overrides the fields that it writes.
        if (sum_load_i) begin
            sum_d = sum_load_data_i;
        end
        if (prod_load_i) begin
            prod_d = prod_load_data_i;
        end
        if (flag_load_i) begin
            n_d = flag_load_data_i[`MSD_FLAG_N_BIT];
            z_d = flag_load_data_i[`MSD_FLAG_Z_BIT];
            c_d = flag_load_data_i[`MSD_FLAG_C_BIT];
            v_d = flag_load_data_i[`MSD_FLAG_V_BIT];
        end

        case (state_q)
            ST_IDLE: begin
                if (repeat_prefix_i) begin
                    cnt_d   = repeat_count_i;
                    armed_d = 1'b1;
                end else if (issue_valid_i) begin
                    exec = dec_half | dec_wide;
                    if (dec_cond) begin
                        // A pending repeat is dropped; the op runs once.
                        cnt_d   = `MSD_RST_CNT;
                        armed_d = 1'b0;
                        done_d  = 1'b1;
                        if (n_q && !z_q) begin
                            prod_d = operand_i;
                        end else if (!n_q && z_q && prod_lt) begin
                            prod_d = operand_i;
                            v_d    = 1'b1;
                        end
                        // Both flags clear: nothing changes.
                    end else if (!exec) begin
                        ill_d   = 1'b1;
                        armed_d = 1'b0;
                    end else if (armed_q && cnt_q != `MSD_RST_CNT) begin
                        // Remaining passes replay from latched copies.
                        state_d = ST_REPT;
                        hsel_d  = opcode_i[`MSD_HALF_SEL_BIT];
                        wide_d  = dec_wide;
                        opnd_d  = operand_i;
                        armed_d = 1'b0;
                    end else begin
                        armed_d = 1'b0;
                        done_d  = 1'b1;
                    end
                end
            end
            ST_REPT: begin
                // Each replay pass reruns the latched instruction and counts
                // down; the last pass returns to idle and signals done.
                exec  = 1'b1;
                cnt_d = cnt_q - `MSD_CNT_ONE;
                if (cnt_q == `MSD_CNT_ONE) begin
                    state_d = ST_IDLE;
                    done_d  = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase

        // One execute stage serves the first pass and every replay, which
        // keeps the flag rules in a single place.
        if (exec) begin
            if (use_wide) begin
                // V is only ever set here, so a flag latched by an earlier
                // replay pass survives every later one.
                if (wide_lt) begin
                    sum_d = use_opnd;
                    v_d   = 1'b1;
                end
                z_d = wide_eq;
                n_d = wide_lt;
                c_d = ~wide_brw;
            end else begin
                // The half max leaves the carry flag alone.
                if (half_lt) begin
                    if (use_hsel) begin
                        sum_d[31:16] = half_op;
                    end else begin
                        sum_d[15:0] = half_op;
                    end
                    v_d = 1'b1;
                end
                n_d = half_lt;
                z_d = half_eq;
            end
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    // One synchronous reset for every register; its branch loads
    // constants only.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            sum_q   <= `MSD_RST_SUM;
            prod_q  <= `MSD_RST_PROD;
            cnt_q   <= `MSD_RST_CNT;
            n_q     <= 1'b0;
            z_q     <= 1'b0;
            c_q     <= 1'b0;
            v_q     <= 1'b0;
            armed_q <= 1'b0;
            done_q  <= 1'b0;
            ill_q   <= 1'b0;
            hsel_q  <= 1'b0;
            wide_q  <= 1'b0;
            opnd_q  <= `MSD_RST_OPND;
        end else begin
            state_q <= state_d;
            sum_q   <= sum_d;
            prod_q  <= prod_d;
            cnt_q   <= cnt_d;
            n_q     <= n_d;
            z_q     <= z_d;
            c_q     <= c_d;
            v_q     <= v_d;
            armed_q <= armed_d;
            done_q  <= done_d;
            ill_q   <= ill_d;
            hsel_q  <= hsel_d;
            wide_q  <= wide_d;
            opnd_q  <= opnd_d;
        end
    end

    // done_o and illegal_o are one-cycle pulses from flip-flops, and
    // busy_o mirrors the replay state.
    // The pipeline must hold off while replayed passes are running.
    assign issue_ready_o       = (state_q == ST_IDLE);
    assign busy_o              = (state_q == ST_REPT);
    assign main_sum_register_o = sum_q;
    assign product_reg_o       = prod_q;
    assign repeat_count_reg_o  = cnt_q;
    assign flag_n_o            = n_q;
    assign flag_z_o            = z_q;
    assign flag_c_o            = c_q;
    assign flag_v_o            = v_q;
    assign done_o              = done_q;
    assign illegal_o           = ill_q;

endmodule // msd_max_select_datapath

// ==========================================================================
// Compare unit shared by the half and the wide maximum
// ==========================================================================
module msd_cmp #(
    parameter W = 16
) (
    input  wire [W-1:0] a_i,
    input  wire [W-1:0] b_i,
    output wire         lt_o,
    output wire         eq_o,
    output wire         brw_o
);

    // Both differences are one bit wider than the operands, so their top
    // bit is the true sign and the true borrow; neither can overflow.
    wire [W:0] sdiff = {a_i[W-1], a_i} - {b_i[W-1], b_i};
    wire [W:0] udiff = {1'b0, a_i} - {1'b0, b_i};

    assign lt_o  = sdiff[W];
    assign eq_o  = (a_i == b_i);
    assign brw_o = udiff[W];

endmodule // msd_cmp
`default_nettype wire

// ==== hdl/msd_map.vh ====
// Opcode patterns, field positions and reset values for the max datapath.
`ifndef MSD_MAP_VH
`define MSD_MAP_VH
// ==========================================================================
// Opcode patterns (upper 24 bits; low 8 bits locate the operand)
// ==========================================================================
`define MSD_OPC_HALF_MAX   24'h560072
`define MSD_OPC_HALF_MASK  24'hfffffe
`define MSD_OPC_COND_MAX   24'h565100
`define MSD_OPC_WIDE_MAX   24'h566100
`define MSD_OPC_MASK_FULL  24'hffffff
// ==========================================================================
// Field positions
// ==========================================================================
`define MSD_HALF_SEL_BIT   8
`define MSD_OPC_TOP        31
`define MSD_OPC_LOW        8
`define MSD_FLAG_N_BIT     3
`define MSD_FLAG_Z_BIT     2
`define MSD_FLAG_C_BIT     1
`define MSD_FLAG_V_BIT     0
// ==========================================================================
// Reset values
// ==========================================================================
`define MSD_RST_SUM        32'h0000_0000
`define MSD_RST_PROD       32'h0000_0000
`define MSD_RST_CNT        16'h0000
`define MSD_RST_OPND       32'h0000_0000
// ==========================================================================
// Counts
// ==========================================================================
`define MSD_CNT_ONE        16'h0001
`endif

// ==== testbench/msd_max_select_datapath_properties.sv ====
// Port-level assertions for the max selection datapath.
`timescale 1ns/1ps
`default_nettype none
`include "msd_map.vh"
module msd_chk (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        issue_valid_i,
    input wire logic        issue_ready_o,
    input wire logic        repeat_prefix_i,
    input wire logic        sum_load_i,
    input wire logic        prod_load_i,
    input wire logic        flag_load_i,
    input wire logic        flag_n_o,
    input wire logic        flag_z_o,
    input wire logic        flag_c_o,
    input wire logic        flag_v_o,
    input wire logic        done_o,
    input wire logic [31:0] opcode_i,
    input wire logic [31:0] operand_i,
    input wire logic [31:0] main_sum_register_o,
    input wire logic [31:0] product_reg_o,
    input wire logic [15:0] repeat_count_reg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // A pending repeat adds passes, so one-pass checks skip it.
    logic arm_q;
    wire [31:0] s = main_sum_register_o;
    wire [31:0] d = operand_i;
    wire go = issue_valid_i && issue_ready_o && !repeat_prefix_i &&
        !sum_load_i && !prod_load_i && !flag_load_i;
    wire one = go && !arm_q;
    wire wide = opcode_i[31:8] == `MSD_OPC_WIDE_MAX;
    wire cnd = opcode_i[31:8] == `MSD_OPC_COND_MAX;
    wire half = (opcode_i[31:8] & `MSD_OPC_HALF_MASK) == `MSD_OPC_HALF_MAX;
    wire lt = $signed(s) < $signed(d);
    wire eq = s == d;
    wire ge = s >= d;
    wire [15:0] hv = opcode_i[8] ? s[31:16] : s[15:0];
    wire hlt = $signed(hv) < $signed(d[15:0]);
    wire heq = hv == d[15:0];
    wire [15:0] hn = hlt ? d[15:0] : hv;
    wire [31:0] hx = opcode_i[8] ? {hn, s[15:0]} : {s[31:16], hn};
    wire vset = !flag_n_o && flag_z_o && product_reg_o < d;
    wire [31:0] px = (flag_n_o && !flag_z_o) || vset ? d : product_reg_o;
    always_ff @(posedge clk_i)
        if (!rst_n_i || go) arm_q <= 1'b0;
        else if (repeat_prefix_i) arm_q <= 1'b1;
    property p_wide;
        one && wide |=> s == ($past(lt) ? $past(d) : $past(s));
    endproperty
    a_wide: assert property (p_wide)
        else $error("wide max result wrong");
    property p_wflags;
        one && wide |=> flag_n_o == $past(lt) && flag_z_o == $past(eq)
            && flag_c_o == $past(ge);
    endproperty
    a_wflags: assert property (p_wflags)
        else $error("wide max flags wrong");
    property p_wv;
        go && wide && (lt || flag_v_o) |=> flag_v_o [*2];
    endproperty
    a_wv: assert property (p_wv)
        else $error("wide max overflow flag wrong");
    property p_half;
        one && half |=> s == $past(hx) && flag_n_o == $past(hlt)
            && flag_z_o == $past(heq);
    endproperty
    a_half: assert property (p_half)
        else $error("half max wrong");
    property p_hv;
        go && half && (hlt || flag_v_o) |=> flag_v_o [*2];
    endproperty
    a_hv: assert property (p_hv)
        else $error("half max overflow flag wrong");
    property p_cnd;
        go && cnd |=> product_reg_o == $past(px);
    endproperty
    a_cnd: assert property (p_cnd)
        else $error("conditional max product wrong");
    property p_cv;
        go && cnd |=> flag_v_o == ($past(flag_v_o) | $past(vset));
    endproperty
    a_cv: assert property (p_cv)
        else $error("conditional max overflow wrong");
    property p_once;
        go && cnd |=> done_o && repeat_count_reg_o == 16'h0000;
    endproperty
    a_once: assert property (p_once)
        else $error("conditional max repeated");
endmodule // msd_chk
bind msd_max_select_datapath msd_chk msd_chk_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
    .issue_ready_o(issue_ready_o), .repeat_prefix_i(repeat_prefix_i),
    .sum_load_i(sum_load_i), .prod_load_i(prod_load_i),
    .flag_load_i(flag_load_i), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o),
    .flag_c_o(flag_c_o), .flag_v_o(flag_v_o), .done_o(done_o),
    .opcode_i(opcode_i), .operand_i(operand_i),
    .main_sum_register_o(main_sum_register_o),
    .product_reg_o(product_reg_o),
    .repeat_count_reg_o(repeat_count_reg_o));
`default_nettype wire

// ==== testbench/msd_pipe_model.sv ====
// Issue-side model of the decode and fetch pipeline.
`timescale 1ns/1ps
`default_nettype none
module msd_pipe_model (
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    output var  logic        valid_o,
    output var  logic        prefix_o,
    output var  logic [15:0] count_o,
    output var  logic [31:0] opcode_o,
    output var  logic [31:0] operand_o
);
    initial {valid_o, prefix_o, count_o, opcode_o, operand_o} = '0;
    // A released bus shows inverted data, so late sampling reads garbage.
    task automatic issue(input logic [31:0] opc, opd,
                         input logic [15:0] n, input bit pre);
        int k;
        @(negedge clk_i);
        if (pre) begin
            prefix_o = 1'b1;
            count_o = n;
            @(negedge clk_i);
            prefix_o = 1'b0;
        end
        {valid_o, opcode_o, operand_o} = {1'b1, opc, opd};
        for (k = 0; k < 50 && ready_i !== 1'b1; k++) @(negedge clk_i);
        @(posedge clk_i);
        @(negedge clk_i);
        {valid_o, opcode_o, operand_o} = {1'b0, ~opc, ~opd};
    endtask
endmodule // msd_pipe_model
`default_nettype wire

// ==== testbench/msd_max_select_datapath_tb_top.sv ====
// Self-checking bench for the max selection datapath.
`timescale 1ns/1ps
`default_nettype none
`include "msd_map.vh"
module msd_max_select_datapath_tb_top;
    logic clk_i = 1'b0, rst_n_i = 1'b0;
    logic sum_load_i = 1'b0, prod_load_i = 1'b0, flag_load_i = 1'b0;
    logic [31:0] sum_load_data_i = '0, prod_load_data_i = '0;
    logic [3:0] flag_load_data_i = '0;
    wire issue_valid_i, repeat_prefix_i, issue_ready_o, busy_o, done_o;
    wire illegal_o, flag_n_o, flag_z_o, flag_c_o, flag_v_o;
    wire [31:0] opcode_i, operand_i, main_sum_register_o, product_reg_o;
    wire [15:0] repeat_count_i, repeat_count_reg_o;
    logic [31:0] m_sum, m_prod;
    logic [3:0] m_f;
    logic [23:0] ops [4];
    int mismatches = 0, total_checks = 0, i;
    always #50 clk_i = ~clk_i;
    msd_max_select_datapath msd_max_select_datapath_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
        .opcode_i(opcode_i), .operand_i(operand_i),
        .issue_ready_o(issue_ready_o), .repeat_prefix_i(repeat_prefix_i),
        .repeat_count_i(repeat_count_i), .sum_load_i(sum_load_i),
        .sum_load_data_i(sum_load_data_i), .prod_load_i(prod_load_i),
        .prod_load_data_i(prod_load_data_i), .flag_load_i(flag_load_i),
        .flag_load_data_i(flag_load_data_i),
        .main_sum_register_o(main_sum_register_o),
        .product_reg_o(product_reg_o),
        .repeat_count_reg_o(repeat_count_reg_o), .flag_n_o(flag_n_o),
        .flag_z_o(flag_z_o), .flag_c_o(flag_c_o), .flag_v_o(flag_v_o),
        .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o));
    msd_pipe_model msd_pipe_model_inst (.clk_i(clk_i),
        .ready_i(issue_ready_o), .valid_o(issue_valid_i),
        .prefix_o(repeat_prefix_i), .count_o(repeat_count_i),
        .opcode_o(opcode_i), .operand_o(operand_i));
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic step(input logic [31:0] op, d, input int n);
        logic lt;
        logic [15:0] h;
        if (op[31:8] == ops[1]) begin
            if (m_f[3] && !m_f[2]) m_prod = d;
            else if (!m_f[3] && m_f[2] && m_prod < d) {m_prod, m_f[0]} = {d, 1'b1};
        end else repeat (n + 1) begin
            h = op[8] ? m_sum[31:16] : m_sum[15:0];
            lt = op[31:8] == ops[0] ? $signed(m_sum) < $signed(d)
                : $signed(h) < $signed(d[15:0]);
            if (op[31:8] == ops[0])
                m_f = {lt, m_sum == d, m_sum >= d, m_v_next(m_f[0], lt)};
            else m_f = {lt, h == d[15:0], m_f[1], m_v_next(m_f[0], lt)};
            if (lt && op[31:8] == ops[0]) m_sum = d;
            else if (lt && op[8]) m_sum[31:16] = d[15:0];
            else if (lt) m_sum[15:0] = d[15:0];
        end
    endtask
    // V latches across passes: a set from any pass survives the rest.
    function automatic logic m_v_next(input logic v, input logic lt);
        return v | lt;
    endfunction
    task automatic load(input logic [31:0] s, p, input logic [3:0] f);
        @(negedge clk_i);
        {sum_load_i, prod_load_i, flag_load_i} = 3'b111;
        {sum_load_data_i, prod_load_data_i, flag_load_data_i} = {s, p, f};
        @(negedge clk_i);
        {sum_load_i, prod_load_i, flag_load_i} = 3'b000;
        {m_sum, m_prod, m_f} = {s, p, f};
    endtask
    task automatic run(input logic [31:0] op, d, input logic [15:0] n,
                       input bit pre);
        int k;
        logic ill;
        logic rep;
        ill = op[31:8] != ops[0] && op[31:8] != ops[1] && op[31:9] != ops[2][23:1];
        rep = pre && !ill && op[31:8] != ops[1];
        if (!ill) step(op, d, pre ? n : 0);
        msd_pipe_model_inst.issue(op, d, n, pre);
        chk(busy_o, rep && n != 16'h0);
        for (k = 0; k < 20 && done_o !== 1'b1 && illegal_o !== 1'b1; k++)
            @(negedge clk_i);
        chk(k, rep ? {16'h0, n} : 32'h0);
        chk({done_o, illegal_o}, {!ill, ill});
        chk(main_sum_register_o, m_sum);
        chk(product_reg_o, m_prod);
        chk({flag_n_o, flag_z_o, flag_c_o, flag_v_o}, m_f);
        chk(repeat_count_reg_o, 32'h0);
    endtask
    initial begin
        ops = '{`MSD_OPC_WIDE_MAX, `MSD_OPC_COND_MAX, `MSD_OPC_HALF_MAX,
                `MSD_OPC_HALF_MAX | 24'h000001};
        i = $urandom(32'h1188ff09);
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        {m_sum, m_prod, m_f} = '0;
        load(32'h8000_0000, 32'h0, 4'h0);
        run({ops[0], 8'h00}, 32'h1, 16'h0, 1'b0);
        run({ops[0], 8'h3c}, 32'h1, 16'h0, 1'b0);
        run({ops[2], 8'h01}, 32'hffff, 16'h0, 1'b0);
        run({ops[3], 8'h00}, 32'h7fff, 16'h3, 1'b1);
        run({ops[0], 8'h00}, 32'h7fff_ffff, 16'h2, 1'b1);
        run(32'h1234_5600, 32'h5, 16'h0, 1'b0);
        // A 64-bit maximum: upper words first, then the conditional pass.
        load(32'h10, 32'h100, 4'h0);
        run({ops[0], 8'h00}, 32'h10, 16'h0, 1'b0);
        run({ops[1], 8'h00}, 32'hffff_0000, 16'h4, 1'b1);
        for (i = 0; i < 60; i++) begin
            if ($urandom_range(0, 1))
                load($urandom, $urandom, {2'($urandom_range(0, 2)), 2'($urandom)});
            run({ops[$urandom_range(0, 3)], 8'($urandom)},
                $urandom_range(0, 3) == 0 ? m_sum : $urandom,
                16'($urandom_range(0, 3)), 1'($urandom));
        end
        end_of_test;
    end
    initial begin
        #2000000;
        mismatches++;
        end_of_test;
    end
endmodule // msd_max_select_datapath_tb_top
`default_nettype wire
